/* hdl/sdl_word_loader.sv */
// Serial converter word loader: 16-bit frame, double-buffered code, shutdown
// What this block does
// - A frame is exactly sixteen bits gathered in a sixteen-bit shift register.
// - MSB first: three command bits, ten code bits, three sub-bits.
// - Bits are accepted only while select is low; idle while high.
// - Data is sampled on each rising serial clock edge while selected.
// - Decode and register updates happen only at the rising edge of select.
// - Command x00 loads input and converter registers and leaves shutdown.
// - Command x01 loads the input register only.
// - Command x10 copies input to converter and leaves shutdown.
// - Command 111 enters shutdown; 011 does nothing; no register changes.
// - The serial port keeps working during shutdown.
// - Shutdown leaves the input register contents intact.
// - Shutdown drives the high-impedance control, released on exit.
// - Converter register holds straight binary, passed unchanged to the core.
// - Reset clears both input and converter registers to zero.
`timescale 1ns/10ps
`default_nettype none
module sdl_word_loader
	import sdl_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	input  wire logic          sel_n,
	input  wire logic          sclk,
	input  wire logic          sdata,
	output sdl_pkg::sdl_code_t input_code_q,
	output sdl_pkg::sdl_code_t converter_code_q,
	output logic               shutdown_q,
	output logic               hiz_ctrl_q
);
	import sdl_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic sel_n_s;
	logic sel_rise;
	logic sel_fall;
	logic sclk_rise;
	logic sdata_s;

	sdl_sync u_sel (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.async_in  (sel_n),
		.reset_val (1'b1),
		.level_q   (sel_n_s),
		.rise      (sel_rise),
		.fall      (sel_fall)
	);
	sdl_sync u_sclk (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.async_in  (sclk),
		.reset_val (1'b0),
		.level_q   (),
		.rise      (sclk_rise),
		.fall      ()
	);
	sdl_sync u_sdata (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.async_in  (sdata),
		.reset_val (1'b0),
		.level_q   (sdata_s),
		.rise      (),
		.fall      ()
	);

	// ----------------------------------------
	// Shift register and edge counter
	// ----------------------------------------
	logic [FRAME_BITS-1:0] shift_q, shift_d;
	logic [CNT_W-1:0]      cnt_q, cnt_d;
	logic                  shift_en;

	assign shift_en = ~sel_n_s & sclk_rise;

	always_comb begin
		shift_d = shift_q;
		cnt_d   = cnt_q;
		if (sel_fall) begin
			cnt_d = CNT_RESET;
		end
		if (shift_en) begin
			shift_d = {shift_q[FRAME_BITS-2:0], sdata_s};
			if (cnt_d != FRAME_COUNT + CNT_ONE) begin
				cnt_d = cnt_d + CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shift_q <= SHIFT_RESET;
			cnt_q   <= CNT_RESET;
		end else begin
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
		end
	end

	// ----------------------------------------
	// Decode at select rising edge
	// ----------------------------------------
	sdl_cmd_e  cmd;
	sdl_code_t code_field;
	logic      cmd_top;
	logic      frame_ok;
	sdl_code_t in_d, cv_d;
	logic      sd_d;

	assign cmd        = sdl_cmd_e'({shift_q[CMD_MID_POS], shift_q[CMD_LOW_POS]});
	assign cmd_top    = shift_q[CMD_TOP_POS];
	assign code_field = shift_q[CODE_MSB_POS:CODE_LSB_POS];
	assign frame_ok   = sel_rise & (cnt_q == FRAME_COUNT);

	always_comb begin
		in_d = input_code_q;
		cv_d = converter_code_q;
		sd_d = shutdown_q;
		if (frame_ok) begin
			unique case (cmd)
				SDL_CMD_LOAD_BOTH: begin
					in_d = code_field;
					cv_d = code_field;
					sd_d = 1'b0;
				end
				SDL_CMD_LOAD_INPUT: begin
					in_d = code_field;
				end
				SDL_CMD_TRANSFER: begin
					cv_d = input_code_q;
					sd_d = 1'b0;
				end
				SDL_CMD_OTHER: begin
					if (cmd_top) begin
						sd_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			input_code_q     <= CODE_RESET;
			converter_code_q <= CODE_RESET;
			shutdown_q       <= 1'b0;
			hiz_ctrl_q       <= 1'b0;
		end else begin
			input_code_q     <= in_d;
			converter_code_q <= cv_d;
			shutdown_q       <= sd_d;
			hiz_ctrl_q       <= sd_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_ignore_short;
		@(posedge ref_clk) disable iff (!rstn)
		(sel_rise && cnt_q != FRAME_COUNT) |=> $stable(input_code_q) && $stable(converter_code_q) && $stable(shutdown_q);
	endproperty
	a_ignore_short: assert property (p_ignore_short) else $error("bad frame changed state");

	property p_no_update_mid_frame;
		@(posedge ref_clk) disable iff (!rstn)
		!sel_rise |=> $stable(input_code_q) && $stable(converter_code_q);
	endproperty
	a_no_update_mid_frame: assert property (p_no_update_mid_frame) else $error("update outside select rise");

	property p_load_both;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_ok && cmd == SDL_CMD_LOAD_BOTH) |=> converter_code_q == $past(code_field) && input_code_q == converter_code_q && !shutdown_q;
	endproperty
	a_load_both: assert property (p_load_both) else $error("load both failed");

	property p_load_input;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_ok && cmd == SDL_CMD_LOAD_INPUT) |=> input_code_q == $past(code_field) && $stable(converter_code_q);
	endproperty
	a_load_input: assert property (p_load_input) else $error("load input failed");

	property p_transfer;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_ok && cmd == SDL_CMD_TRANSFER) |=> converter_code_q == $past(input_code_q) && !shutdown_q;
	endproperty
	a_transfer: assert property (p_transfer) else $error("transfer failed");

	property p_shutdown;
		@(posedge ref_clk) disable iff (!rstn)
		(frame_ok && cmd == SDL_CMD_OTHER) |=> $stable(input_code_q) && $stable(converter_code_q) && shutdown_q == ($past(cmd_top) | $past(shutdown_q));
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown or nop failed");

	property p_hiz;
		@(posedge ref_clk) disable iff (!rstn)
		!frame_ok |=> $stable(hiz_ctrl_q) && hiz_ctrl_q == shutdown_q;
	endproperty
	a_hiz: assert property (p_hiz) else $error("hiz control mismatch");

	property p_shift_sel_high;
		@(posedge ref_clk) disable iff (!rstn)
		sel_n_s |=> $stable(shift_q);
	endproperty
	a_shift_sel_high: assert property (p_shift_sel_high) else $error("shift while deselected");

	property p_shift_in;
		@(posedge ref_clk) disable iff (!rstn)
		shift_en |=> shift_q[0] == $past(sdata_s) && shift_q[FRAME_BITS-1:1] == $past(shift_q[FRAME_BITS-2:0]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("shift in wrong");

	property p_count_saturates;
		@(posedge ref_clk) disable iff (!rstn)
		(cnt_q == FRAME_COUNT + CNT_ONE && !sel_fall) |=> cnt_q == FRAME_COUNT + CNT_ONE;
	endproperty
	a_count_saturates: assert property (p_count_saturates) else $error("edge count left saturation");
endmodule // sdl_word_loader
`default_nettype wire

/* hdl/sdl_pkg.sv */
// Package of constants and types for the serial converter word loader
package sdl_pkg;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned CODE_BITS  = 10;
	localparam int unsigned CMD_BITS   = 3;
	localparam int unsigned SUB_BITS   = 3;
	localparam int unsigned CNT_W      = 5;
	// Field positions inside the frame, bit 15 arrives first
	localparam int unsigned CMD_TOP_POS  = 15;
	localparam int unsigned CMD_MID_POS  = 14;
	localparam int unsigned CMD_LOW_POS  = 13;
	localparam int unsigned CODE_MSB_POS = 12;
	localparam int unsigned CODE_LSB_POS = 3;
	localparam logic [CNT_W-1:0] FRAME_COUNT = 5'h10;
	localparam logic [CNT_W-1:0] CNT_RESET   = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
	localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
	localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
	// Serial clock limits
	localparam int unsigned SCLK_MAX_HZ = 10_000_000;
	typedef logic [CODE_BITS-1:0] sdl_code_t;
	typedef enum logic [1:0] {
		SDL_CMD_LOAD_BOTH  = 2'h0,
		SDL_CMD_LOAD_INPUT = 2'h1,
		SDL_CMD_TRANSFER   = 2'h2,
		SDL_CMD_OTHER      = 2'h3
	} sdl_cmd_e;
endpackage

/* hdl/sdl_sync.sv */
// Two-flop synchroniser with registered edge detection
`timescale 1ns/10ps
`default_nettype none
module sdl_sync (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic async_in,
	input  wire logic reset_val,
	output logic      level_q,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= async_in ^ reset_val;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign level_q = sync_q ^ reset_val;
	assign rise    = (sync_q ^ reset_val) & ~(prev_q ^ reset_val);
	assign fall    = ~(sync_q ^ reset_val) & (prev_q ^ reset_val);
endmodule // sdl_sync
`default_nettype wire

/* sim/sdl_host_model.sv */
// Host serial controller model driving select, serial clock and data
`timescale 1ns/10ps
`default_nettype none
module sdl_host_model (
	input  wire logic ref_clk,
	output logic      sel_n,
	output logic      sclk,
	output logic      sdata
);
	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	initial begin
		sel_n = 1'b1;
		sclk  = 1'b0;
		sdata = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame transfer
	// ------------------------------------------------------------
	// Half period of eight system cycles, 160 ns clock
	task automatic half();
		repeat (8) @(posedge ref_clk);
		#1;
	endtask

	task automatic send(input logic [15:0] w, input int n, input bit sel_on, input bit split);
		logic [15:0] word;
		int          i;
		word = {w[15:3], 3'h0};
		if (sel_on) begin
			sel_n = 1'b0;
		end
		for (i = 0; i < n; i++) begin
			sdata = word[15 - (i % 16)];
			half();
			sclk = 1'b1;
			half();
			sclk = 1'b0;
			if (split && i == 7) begin
				half();
			end
		end
		half();
		sdata = ~sdata;
		sel_n = 1'b1;
		half();
	endtask
endmodule // sdl_host_model
`default_nettype wire

/* sim/sdl_word_loader_test.sv */
// Self-checking testbench of the serial converter word loader
`timescale 1ns/10ps
`default_nettype none
module sdl_word_loader_test;
	import sdl_pkg::*;
	logic      ref_clk;
	logic      rstn;
	logic      sel_n;
	logic      sclk;
	logic      sdata;
	sdl_code_t input_code_q;
	sdl_code_t converter_code_q;
	logic      shutdown_q;
	logic      hiz_ctrl_q;
	sdl_code_t exp_in;
	sdl_code_t exp_cv;
	logic      exp_sd;
	int        err_total;
	int        n_tests;
	int        t_num;

	// ------------------------------------------------------------
	// Instances and clock
	// ------------------------------------------------------------
	sdl_word_loader u_dut (.ref_clk(ref_clk), .rstn(rstn), .sel_n(sel_n), .sclk(sclk), .sdata(sdata),
		.input_code_q(input_code_q), .converter_code_q(converter_code_q),
		.shutdown_q(shutdown_q), .hiz_ctrl_q(hiz_ctrl_q));
	sdl_host_model u_host (.ref_clk(ref_clk), .sel_n(sel_n), .sclk(sclk), .sdata(sdata));

	always #5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_all();
		check("input_code_q", input_code_q, exp_in);
		check("converter_code_q", converter_code_q, exp_cv);
		check("shutdown_q", {9'h0, shutdown_q}, {9'h0, exp_sd});
		check("hiz_ctrl_q", {9'h0, hiz_ctrl_q}, {9'h0, exp_sd});
	endtask

	task automatic do_frame(input logic [2:0] cmd, input sdl_code_t code, input int n, input bit sel_on,
		input bit split);
		if (sel_on && n == 16) begin
			case (cmd[1:0])
				2'h0: begin
					exp_in = code;
					exp_cv = code;
					exp_sd = 1'b0;
				end
				2'h1: begin
					exp_in = code;
				end
				2'h2: begin
					exp_cv = exp_in;
					exp_sd = 1'b0;
				end
				default: begin
					if (cmd[2]) begin
						exp_sd = 1'b1;
					end
				end
			endcase
		end
		u_host.send({cmd, code, 3'h0}, n, sel_on, split);
		repeat (8) @(posedge ref_clk);
		#1;
		check_all();
		t_num++;
		$display("test %0d done", t_num);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk   = 1'b0;
		rstn      = 1'b0;
		err_total = 0;
		n_tests   = 0;
		t_num     = 0;
		exp_in    = 10'h000;
		exp_cv    = 10'h000;
		exp_sd    = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check_all();
		do_frame(3'h1, 10'h2a5, 16, 1'b1, 1'b0);
		do_frame(3'h2, 10'h000, 16, 1'b1, 1'b0);
		do_frame(3'h4, 10'h3ff, 16, 1'b1, 1'b1);
		do_frame(3'h7, 10'h155, 16, 1'b1, 1'b0);
		do_frame(3'h5, 10'h155, 16, 1'b1, 1'b0);
		do_frame(3'h6, 10'h0f0, 16, 1'b1, 1'b0);
		do_frame(3'h3, 10'h3c3, 16, 1'b1, 1'b0);
		do_frame(3'h7, 10'h000, 16, 1'b1, 1'b1);
		do_frame(3'h0, 10'h001, 16, 1'b1, 1'b0);
		do_frame(3'h0, 10'h0aa, 15, 1'b1, 1'b0);
		do_frame(3'h0, 10'h0aa, 17, 1'b1, 1'b0);
		do_frame(3'h0, 10'h0aa, 16, 1'b0, 1'b0);
		do_frame(3'h4, 10'h3c3, 16, 1'b1, 1'b0);
		do_frame(3'h7, 10'h000, 16, 1'b1, 1'b0);
		rstn   = 1'b0;
		exp_in = 10'h000;
		exp_cv = 10'h000;
		exp_sd = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check_all();
		t_num++;
		$display("test %0d done", t_num);
		do_frame(3'h1, 10'h0f0, 16, 1'b1, 1'b0);
		stop_test();
	end
endmodule // sdl_word_loader_test
`default_nettype wire
